/* File: verilog/scd_clock_divider.sv */
// Purpose: system clock divider with ratio register and prescaler chain
// Assumes: clock is the oscillator at twice its rate; osc_level_pin is the raw oscillator level
// Notes:   the system clock is a flop-driven phi level plus a one-cycle sys_tick per period
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/10ps
// Behaviour
// - ratio select 00, 01, 10, 11 makes the system clock the oscillator divided by 1, 2, 4 and 8.
// - reset and hardware standby load the division control register with its initial value, ratio undivided.
// - software standby leaves the division control register untouched.
// - the upper six register bits ignore writes and read back as ones.
// - the division control register is an 8-bit read/write register at low address ff5d.
// - a new ratio is accepted at run time without reset, and the divided clock drives the phi pin.
// - prescalers divide the system clock into ticks from divide-by-2 to divide-by-4096.
// - the oscillator duty is corrected before division when the oscillator runs at 5 MHz or more.
module scd_clock_divider
  import scd_pkg::*;
(
  // clock and reset
  input  wire logic                    clock,
  input  wire logic                    rst_n,
  input  wire logic                    ce,
  // register port
  input  wire logic [15:0]             addr,
  input  wire logic [7:0]              wdata,
  input  wire logic                    we,
  input  wire logic                    re,
  output logic [7:0]                   rdata,
  // power modes and oscillator
  input  wire logic                    hw_standby_pin,
  input  wire logic                    sw_standby,
  input  wire logic                    osc_level_pin,
  // system clock
  output logic                         phi_out,
  output logic                         phi_oe,
  output logic                         sys_tick,
  output logic [PRESC_STAGES-1:0]      presc_tick
);

  scd_state_t s_reg;
  scd_state_t s_next;

  logic       hw_standby;
  logic       run;
  logic       wr_hit;
  logic [2:0] half_last;
  logic       presc_clear;

  assign hw_standby  = s_reg.hw_s2;
  assign run         = !hw_standby && !sw_standby;
  assign wr_hit      = we && (addr == DIVCTL_ADDR);
  assign presc_clear = !run;

  // half period in clock cycles minus one: 0, 1, 3, 7
  always_comb begin
    unique case (s_reg.active_ratio)
      2'b00: half_last = 3'h0;
      2'b01: half_last = 3'h1;
      2'b10: half_last = 3'h3;
      2'b11: half_last = 3'h7;
    endcase
  end

  always_comb begin
    s_next = s_reg;
    s_next.sys_tick = 1'b0;
    s_next.hw_s1  = hw_standby_pin;
    s_next.hw_s2  = s_reg.hw_s1;
    s_next.osc_s1 = osc_level_pin;
    s_next.osc_s2 = s_reg.osc_s1;

    // read data stands only in the cycle after the strobe
    s_next.rdata = IDLE_RDATA;
    if (re) begin
      if (addr == DIVCTL_ADDR) begin
        s_next.rdata = {DIVCTL_RSVD, s_reg.ratio_sel};
      end else begin
        s_next.rdata = UNMAPPED_RDATA;
      end
    end

    if (hw_standby) begin
      // phi pin floats and the ratio reinitialises
      s_next.ratio_sel    = RATIO_RESET;
      s_next.active_ratio = RATIO_RESET;
      s_next.half_cnt     = 3'h0;
      s_next.phi          = 1'b0;
      s_next.phi_oe       = 1'b0;
    end else begin
      s_next.phi_oe = 1'b1;
      if (wr_hit) begin
        // only the ratio bits are stored, upper bits stay ones
        s_next.ratio_sel = wdata[RATIO_MSB:RATIO_LSB];
      end
      if (sw_standby) begin
        // register kept, phi parked high, divider restarts on exit
        s_next.phi      = 1'b1;
        s_next.half_cnt = 3'h0;
      end else if (!DUTY_ADJ_ON && s_reg.active_ratio == 2'b00) begin
        // slow oscillator: pass the raw waveform, no duty correction
        s_next.phi = s_reg.osc_s2;
        if (s_reg.osc_s2 && !s_reg.phi) begin
          s_next.active_ratio = s_reg.ratio_sel;
          s_next.sys_tick     = 1'b1;
        end
      end else if (s_reg.half_cnt == half_last) begin
        // equal high and low phases give the corrected duty
        s_next.half_cnt = 3'h0;
        s_next.phi      = !s_reg.phi;
        if (!s_reg.phi) begin
          // new ratio only at a rising phi edge, never mid-phase
          s_next.active_ratio = s_reg.ratio_sel;
          s_next.sys_tick     = 1'b1;
        end
      end else begin
        s_next.half_cnt = s_reg.half_cnt + 3'h1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s_reg <= STATE_RESET;
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  assign rdata    = s_reg.rdata;
  assign phi_out  = s_reg.phi;
  assign phi_oe   = s_reg.phi_oe;
  assign sys_tick = s_reg.sys_tick;

  scd_prescaler u_presc (
    .clock      (clock),
    .rst_n      (rst_n),
    .ce         (ce),
    .clear      (presc_clear),
    .sys_tick   (s_reg.sys_tick),
    .presc_tick (presc_tick)
  );

  // helper for checks only: cycles phi has held its level while running
  logic [3:0] hold_cnt;
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      hold_cnt <= 4'h0;
    end else if (ce) begin
      if (!run || s_next.phi != s_reg.phi) begin
        hold_cnt <= 4'h0;
      end else if (hold_cnt != 4'hf) begin
        hold_cnt <= hold_cnt + 4'h1;
      end
    end
  end

  AST_PHASE_LEN: assert property (@(posedge clock) disable iff (!rst_n)
    ce && run && DUTY_ADJ_ON && s_reg.phi && !s_next.phi |-> hold_cnt == {1'b0, half_last})
    else $error("phi high phase does not match ratio");

  AST_RESET_VALUE: assert property (@(posedge clock)
    !rst_n |=> s_reg.ratio_sel == RATIO_RESET && !phi_oe)
    else $error("ratio not initialised by reset");

  AST_HW_STANDBY: assert property (@(posedge clock) disable iff (!rst_n)
    ce && hw_standby |=> s_reg.ratio_sel == RATIO_RESET && !phi_oe)
    else $error("ratio not initialised in hardware standby");

  AST_SW_KEEP: assert property (@(posedge clock) disable iff (!rst_n)
    sw_standby && !hw_standby && !wr_hit |=> $stable(s_reg.ratio_sel))
    else $error("ratio lost in software standby");

  AST_RSVD_ONES: assert property (@(posedge clock) disable iff (!rst_n)
    ce && re && addr == DIVCTL_ADDR |=> rdata[7:2] == 6'h3f && rdata[1:0] == $past(s_reg.ratio_sel))
    else $error("register readback wrong");

  AST_WRITE: assert property (@(posedge clock) disable iff (!rst_n)
    ce && wr_hit && !hw_standby |=> s_reg.ratio_sel == $past(wdata[1:0]))
    else $error("ratio write not stored");

  AST_APPLY: assert property (@(posedge clock) disable iff (!rst_n)
    ce && run && DUTY_ADJ_ON && s_reg.ratio_sel != s_reg.active_ratio
      |-> ##[1:17] (s_reg.active_ratio == s_reg.ratio_sel || !ce || !run))
    else $error("new ratio not applied in time");

  AST_UNDIV_TOGGLE: assert property (@(posedge clock) disable iff (!rst_n)
    DUTY_ADJ_ON && ce && run && s_reg.active_ratio == 2'b00 && s_reg.half_cnt == 3'h0
      |=> phi_out != $past(phi_out))
    else $error("undivided phi not toggling every cycle");

  AST_BOUNDARY: assert property (@(posedge clock) disable iff (!rst_n)
    !hw_standby && !$past(hw_standby) && $changed(s_reg.active_ratio) |-> $rose(phi_out) && sys_tick)
    else $error("ratio changed off a period boundary");

  AST_LOW_LEN: assert property (@(posedge clock) disable iff (!rst_n)
    ce && run && DUTY_ADJ_ON && !s_reg.phi && s_next.phi |-> hold_cnt == {1'b0, half_last})
    else $error("phi low phase does not match ratio");

  AST_TICK_EDGE: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(sys_tick) |-> $rose(phi_out))
    else $error("system tick without rising phi");

  AST_TICK_SINGLE: assert property (@(posedge clock) disable iff (!rst_n)
    ce && sys_tick |=> !sys_tick)
    else $error("system tick longer than one cycle");

  AST_RDATA_IDLE: assert property (@(posedge clock) disable iff (!rst_n)
    ce && !re |=> rdata == IDLE_RDATA)
    else $error("read data not idle without a read");

  AST_UNMAPPED_READ: assert property (@(posedge clock) disable iff (!rst_n)
    ce && re && addr != DIVCTL_ADDR |=> rdata == UNMAPPED_RDATA)
    else $error("unmapped read returned register data");

  AST_NO_STRAY_WRITE: assert property (@(posedge clock) disable iff (!rst_n)
    ce && !wr_hit && !hw_standby |=> $stable(s_reg.ratio_sel))
    else $error("ratio changed without a register write");

  AST_OE_RUN: assert property (@(posedge clock) disable iff (!rst_n)
    ce && !hw_standby |=> phi_oe)
    else $error("phi pin not driven outside hardware standby");

  AST_SW_PARK: assert property (@(posedge clock) disable iff (!rst_n)
    ce && sw_standby && !hw_standby |=> phi_out && phi_oe)
    else $error("phi not parked high in software standby");

endmodule

/* File: verilog/scd_pkg.sv */
// Purpose: shared constants and state type for the system clock divider
// Assumes: clock runs at twice the oscillator rate, so one oscillator cycle is two clock cycles
// Notes:   register offset is the low 16 bits of the register address
package scd_pkg;

  // clock and oscillator rates
  localparam int unsigned CLK_FREQ_HZ     = 100_000_000;
  localparam int unsigned OSC_FREQ_HZ     = CLK_FREQ_HZ / 2;
  localparam int unsigned DUTY_ADJ_MIN_HZ = 5_000_000;
  localparam logic        DUTY_ADJ_ON     = (OSC_FREQ_HZ >= DUTY_ADJ_MIN_HZ);

  // register map
  localparam logic [15:0] DIVCTL_ADDR     = 16'hff5d;
  localparam logic [7:0]  DIVCTL_RESET    = 8'hfc;
  localparam logic [5:0]  DIVCTL_RSVD     = 6'h3f;
  localparam int unsigned RATIO_LSB       = 0;
  localparam int unsigned RATIO_MSB       = 1;
  localparam logic [1:0]  RATIO_RESET     = DIVCTL_RESET[RATIO_MSB:RATIO_LSB];
  localparam logic [7:0]  UNMAPPED_RDATA  = 8'h00;
  localparam logic [7:0]  IDLE_RDATA      = 8'h00;

  // prescaler: stage k ticks once every 2^(k+1) system clocks
  localparam int unsigned PRESC_STAGES    = 12;

  // all state of the divider
  typedef struct packed {
    logic [1:0] ratio_sel;
    logic [1:0] active_ratio;
    logic [2:0] half_cnt;
    logic       phi;
    logic       phi_oe;
    logic       sys_tick;
    logic [7:0] rdata;
    logic       hw_s1;
    logic       hw_s2;
    logic       osc_s1;
    logic       osc_s2;
  } scd_state_t;

  localparam scd_state_t STATE_RESET = '{
    ratio_sel:    RATIO_RESET,
    active_ratio: RATIO_RESET,
    half_cnt:     3'h0,
    phi:          1'b0,
    phi_oe:       1'b0,
    sys_tick:     1'b0,
    rdata:        IDLE_RDATA,
    hw_s1:        1'b0,
    hw_s2:        1'b0,
    osc_s1:       1'b0,
    osc_s2:       1'b0
  };

endpackage

/* File: verilog/scd_prescaler.sv */
// Purpose: prescaler chain giving peripheral clock ticks from system clock/2 to system clock/4096
// Assumes: sys_tick is one clock wide, once per system clock period
// Notes:   clear holds the chain in reset, as peripherals are halted and reset in standby
`timescale 1ns/10ps
module scd_prescaler
  import scd_pkg::*;
(
  // clock and reset
  input  wire logic                    clock,
  input  wire logic                    rst_n,
  input  wire logic                    ce,
  // control
  input  wire logic                    clear,
  input  wire logic                    sys_tick,
  // ticks
  output logic [PRESC_STAGES-1:0]      presc_tick
);

  typedef struct packed {
    logic [PRESC_STAGES-1:0] cnt;
    logic [PRESC_STAGES-1:0] tick;
  } scd_presc_state_t;

  scd_presc_state_t s_reg;
  scd_presc_state_t s_next;
  logic [PRESC_STAGES-1:0] wrap;

  // stage k fires when the low k+1 count bits wrap
  genvar g;
  generate
    for (g = 0; g < PRESC_STAGES; g++) begin : g_wrap
      assign wrap[g] = &s_reg.cnt[g:0];
    end
  endgenerate

  always_comb begin
    s_next = s_reg;
    s_next.tick = '0;
    if (clear) begin
      s_next.cnt = '0;
    end else if (sys_tick) begin
      s_next.cnt  = s_reg.cnt + 1'b1;
      s_next.tick = wrap;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s_reg <= '0;
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  assign presc_tick = s_reg.tick;

  // every slower tick coincides with the next faster one
  generate
    for (g = 1; g < PRESC_STAGES; g++) begin : g_nest
      AST_PRESC_NEST: assert property (@(posedge clock) disable iff (!rst_n)
        s_reg.tick[g] |-> s_reg.tick[g-1])
        else $error("slower prescaler tick without faster tick");
    end
  endgenerate

  AST_PRESC_HALF: assert property (@(posedge clock) disable iff (!rst_n)
    ce && !clear && sys_tick && s_reg.cnt[0] |=> s_reg.tick[0])
    else $error("divide-by-two tick missing");

endmodule

/* File: tb/scd_osc_source.sv */
// Purpose: external clock source model feeding the raw oscillator level pin
// Assumes: oscillator runs at half the bench clock rate, one level change per clock
// Notes:   single-ended arrangement, so the level is parked high in any standby
`timescale 1ns/10ps
module scd_osc_source (
  // clock
  input  wire logic clock,
  // power mode seen by the source
  input  wire logic standby,
  // clock level to the device
  output logic      osc_level
);
  initial osc_level = 1'b1;

  // a low park level would look like a stuck-low clock edge on standby exit
  always @(posedge clock) begin
    if (standby) begin
      osc_level <= 1'b1;
    end else begin
      osc_level <= ~osc_level;
    end
  end
endmodule

/* File: tb/system_clock_divider_bench.sv */
// Purpose: self-checking bench for the system clock divider
// Assumes: one clock domain at 100 MHz, register bus with one-cycle strobes
// Notes:   the long settle time before reset release is shortened to 8 cycles
`timescale 1ns/10ps
module system_clock_divider_bench;
  import scd_pkg::*;
  logic                    clock, rst_n, ce, we, re, hw_standby_pin, sw_standby, osc_level_pin;
  logic                    phi_out, phi_oe, sys_tick;
  logic [15:0]             addr;
  logic [7:0]              wdata, rdata;
  logic [PRESC_STAGES-1:0] presc_tick;
  int                      failures, check_count, cycles;

  scd_clock_divider dut (.clock(clock), .rst_n(rst_n), .ce(ce), .addr(addr), .wdata(wdata), .we(we), .re(re),
    .rdata(rdata), .hw_standby_pin(hw_standby_pin), .sw_standby(sw_standby), .osc_level_pin(osc_level_pin),
    .phi_out(phi_out), .phi_oe(phi_oe), .sys_tick(sys_tick), .presc_tick(presc_tick));
  scd_osc_source osc_src (.clock(clock), .standby(sw_standby | hw_standby_pin), .osc_level(osc_level_pin));

  always #5 clock = ~clock;

  // hang guard: the whole run needs well under this
  always @(posedge clock) begin
    cycles++;
    if (cycles == 40000) begin
      failures++;
      give_verdict();
    end
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic reg_write(input logic [15:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    we <= 1'b1;
    @(posedge clock);
    we <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe, then idle
  task automatic reg_read(input logic [15:0] a, input logic [7:0] exp);
    @(posedge clock);
    addr <= a;
    re <= 1'b1;
    @(posedge clock);
    re <= 1'b0;
    #1 check(16'(rdata), 16'(exp));
    @(posedge clock);
    #1 check(16'(rdata), 16'(IDLE_RDATA));
  endtask

  // skip one rising edge so the new ratio is surely active, then time one period
  task automatic measure_ratio(input int r);
    int n, hi, lo;
    n = 0;
    repeat (2) begin
      do begin
        @(posedge clock);
        #1 n++;
      end while (sys_tick !== 1'b1 && n < 100);
    end
    hi = 0;
    lo = 0;
    while (phi_out === 1'b1 && hi < 100) begin
      hi++;
      @(posedge clock);
      #1;
    end
    while (phi_out === 1'b0 && lo < 100) begin
      lo++;
      @(posedge clock);
      #1;
    end
    check(16'(hi), 16'(1 << r));
    check(16'(lo), 16'(1 << r));
  endtask

  task automatic test_reset_values();
    reg_read(DIVCTL_ADDR, DIVCTL_RESET);
    check(16'(phi_oe), 16'h0001);
  endtask

  task automatic test_register_bits();
    reg_write(DIVCTL_ADDR, 8'h00);
    reg_write(DIVCTL_ADDR, 8'h02);
    reg_read(DIVCTL_ADDR, {DIVCTL_RSVD, 2'b10});
    reg_write(16'hff5c, 8'h01);
    reg_read(DIVCTL_ADDR, 8'hfe);
    reg_read(16'hff5e, UNMAPPED_RDATA);
  endtask

  task automatic test_ratios();
    for (int r = 0; r < 4; r++) begin
      reg_write(DIVCTL_ADDR, 8'(r));
      measure_ratio(r);
    end
    reg_write(DIVCTL_ADDR, 8'h00);
    measure_ratio(0);
  endtask

  task automatic test_prescaler();
    int n, ticks, p0;
    n = 0;
    ticks = 0;
    p0 = 0;
    do begin
      @(posedge clock);
      #1 n++;
    end while (presc_tick[PRESC_STAGES-1] !== 1'b1 && n < 10000);
    do begin
      @(posedge clock);
      #1 n++;
      ticks += int'(sys_tick === 1'b1);
      p0 += int'(presc_tick[0] === 1'b1);
    end while (presc_tick[PRESC_STAGES-1] !== 1'b1 && n < 20000);
    check(16'(ticks), 16'd4096);
    check(16'(p0), 16'd2048);
  endtask

  task automatic test_sw_standby();
    reg_write(DIVCTL_ADDR, 8'h02);
    @(posedge clock);
    sw_standby <= 1'b1;
    repeat (16) @(posedge clock);
    #1 check(16'(phi_out), 16'h0001);
    reg_read(DIVCTL_ADDR, 8'hfe);
    @(posedge clock);
    sw_standby <= 1'b0;
    measure_ratio(2);
  endtask

  task automatic test_hw_standby();
    @(posedge clock);
    hw_standby_pin <= 1'b1;
    repeat (4) @(posedge clock);
    reg_write(DIVCTL_ADDR, 8'h03);
    #1 check(16'(phi_oe), 16'h0000);
    @(posedge clock);
    hw_standby_pin <= 1'b0;
    repeat (4) @(posedge clock);
    reg_read(DIVCTL_ADDR, DIVCTL_RESET);
    check(16'(phi_oe), 16'h0001);
    measure_ratio(0);
  endtask

  task automatic give_verdict();
    $display("checks=%0d failures=%0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    clock = 1'b0;
    rst_n = 1'b0;
    ce = 1'b1;
    we = 1'b0;
    re = 1'b0;
    addr = 16'h0000;
    wdata = 8'h00;
    hw_standby_pin = 1'b0;
    sw_standby = 1'b0;
    // reset held while the source settles, shortened for the run
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
    test_reset_values();
    test_register_bits();
    test_ratios();
    test_prescaler();
    test_sw_standby();
    test_hw_standby();
    give_verdict();
  end
endmodule
